// >>> logic/can_irq_wakeup_busoff.sv
// Top: registers, flags, interrupt outputs, mode handshakes and wake-up of the CAN event block.
// Assumes frame engine events arrive as one-cycle pulses on ref_clk; bus_rx_pin is asynchronous.
`timescale 1ns/1ps
// Summary of operation
// - With wake enable set, bus activity in sleep or power-down ends sleep mode and clears the sleep request.
// - Wake filter select applies a low-pass to the receive line before wake detection.
// - Four interrupt outputs, each locally maskable and gated by global mask.
// - Transmit empty flag set while buffer is not scheduled.
// - Receive-full flag set when a received message reaches the foreground buffer outside sleep mode.
// - Receive-full flag set again when the next queued message arrives.
// - With wake enable set, bus activity in sleep or power-down sets the wake flag.
// - Wake interrupt needs prior sleep acknowledge, wake enable and wake interrupt enable.
// - Receive FIFO overflow sets the overrun flag, raising the error interrupt.
// - Error counter range change sets status-change flag and updates state fields.
// - Interrupt stays asserted while any enabled flag stays set.
// - Writing one clears a flag; writing zero leaves it.
// - A clear has no effect while the setting condition still holds.
// - Default bus-off recovery is automatic after 128 runs of 11 recessive bits.
// - User recovery mode waits for the 128 runs and the hold bit cleared.
// - Init acknowledge rises only once all parts are in init mode.
// - Sleep acknowledge rises only once sleep is really active.
module can_irq_wakeup_busoff (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [7:0]       regRdata,
    input  wire logic        bus_rx_pin,
    input  wire logic        globalMask_n,
    input  wire logic        powerDown,
    input  wire logic        bitTick,
    input  wire logic        busIdle,
    input  wire logic [2:0]  txScheduled,
    input  wire logic        rxToForeground,
    input  wire logic        rxFifoOverflow,
    input  wire logic [1:0]  txErrState,
    input  wire logic [1:0]  rxErrState,
    input  wire logic        busOffIn,
    output logic             busOffRecover,
    output logic             initMode,
    output logic             sleepMode,
    output logic             wakeIrq,
    output logic             errIrq,
    output logic             rxIrq,
    output logic             txIrq
);
    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] rier;
        logic [2:0] tier;
        logic       rxFull;
        logic       overrun;
        logic       statChg;
        logic       wake;
        logic [2:0] txEmpty;
        logic [1:0] txStateField;
        logic [1:0] rxStateField;
        logic       initAck;
        logic       sleepAck;
        logic       sleptBeforePd;
        logic [1:0] initSync;
        logic       busoffHold;
        logic [1:0] rxPipe;
        logic [7:0] rdata;
    } st_s;
    st_s stateFf;
    st_s nxtState;

    can_evt_if lnk ();
    logic      wakeHit;
    logic      rxSync;
    logic      lowPower;

    assign rxSync   = stateFf.rxPipe[1];
    assign lowPower = stateFf.sleepAck || powerDown;

    // Without wake enable the line is masked, so only clearing the sleep request ends sleep
    wake_filter u_wake (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .rxSync   (rxSync),
        .filterOn (stateFf.ctl1[can_evt_pkg::C1_WAKE_FILTER_SELECT]),
        .armed    (lowPower && stateFf.ctl0[can_evt_pkg::C0_WAKE_ENABLE]),
        .wakeHit  (wakeHit)
    );

    assign lnk.busOff      = busOffIn;
    assign lnk.bitTick     = bitTick && !stateFf.sleepAck;
    assign lnk.rxRecessive = rxSync;
    assign lnk.userMode    = stateFf.ctl1[can_evt_pkg::C1_BUSOFF_USER_RECOVERY];
    assign lnk.holdSet     = stateFf.busoffHold;

    busoff_recovery u_bo (
        .ref_clk (ref_clk),
        .rst     (rst),
        .lnk     (lnk.rec)
    );

    always_comb begin
        nxtState = stateFf;
        nxtState.rxPipe = {stateFf.rxPipe[0], bus_rx_pin};

        if (regWr) begin
            unique case (regAddr)
                can_evt_pkg::CTL0_OFS: begin
                    // Requests cannot be withdrawn before their acknowledge
                    nxtState.ctl0 = regWdata;
                    if (stateFf.ctl0[can_evt_pkg::C0_INIT_REQUEST] && !stateFf.initAck) begin
                        nxtState.ctl0[can_evt_pkg::C0_INIT_REQUEST] = 1'b1;
                    end
                    if (stateFf.ctl0[can_evt_pkg::C0_SLEEP_REQUEST] && !stateFf.sleepAck) begin
                        nxtState.ctl0[can_evt_pkg::C0_SLEEP_REQUEST] = 1'b1;
                    end
                end
                can_evt_pkg::CTL1_OFS: nxtState.ctl1 = regWdata;
                can_evt_pkg::RIER_OFS: nxtState.rier = regWdata;
                can_evt_pkg::TIER_OFS: nxtState.tier = regWdata[2:0];
                can_evt_pkg::MISC_OFS: begin
                    if (regWdata[0]) begin
                        nxtState.busoffHold = 1'b0;
                    end
                end
                can_evt_pkg::RFLG_OFS: begin
                    if (regWdata[can_evt_pkg::RF_RXF]) nxtState.rxFull = 1'b0;
                    if (regWdata[can_evt_pkg::RF_OVR]) nxtState.overrun = 1'b0;
                    if (regWdata[can_evt_pkg::RF_CSC]) nxtState.statChg = 1'b0;
                    if (regWdata[can_evt_pkg::RF_WUP]) nxtState.wake = 1'b0;
                end
                can_evt_pkg::TFLG_OFS: begin
                    nxtState.txEmpty = stateFf.txEmpty & ~regWdata[2:0];
                end
                default: ;
            endcase
        end

        // Set wins over clear, and a prevailing condition keeps the flag
        nxtState.txEmpty = nxtState.txEmpty | ~txScheduled;
        if (rxToForeground && !stateFf.sleepAck) begin
            nxtState.rxFull = 1'b1;
        end
        if (rxFifoOverflow) begin
            nxtState.overrun = 1'b1;
        end
        if (txErrState != stateFf.txStateField || rxErrState != stateFf.rxStateField) begin
            nxtState.statChg      = 1'b1;
            nxtState.txStateField = txErrState;
            nxtState.rxStateField = rxErrState;
        end

        if (stateFf.sleepAck && !powerDown) begin
            nxtState.sleptBeforePd = 1'b1;
        end else if (!lowPower && !stateFf.wake) begin
            // Held while the wake flag stands, so the wake interrupt lasts until cleared
            nxtState.sleptBeforePd = 1'b0;
        end
        if (wakeHit) begin
            nxtState.wake = 1'b1;
            nxtState.sleepAck = 1'b0;
            nxtState.ctl0[can_evt_pkg::C0_SLEEP_REQUEST] = 1'b0;
        end else if (nxtState.ctl0[can_evt_pkg::C0_SLEEP_REQUEST] && busIdle && (&stateFf.txEmpty)) begin
            nxtState.sleepAck = 1'b1;
        end else if (!nxtState.ctl0[can_evt_pkg::C0_SLEEP_REQUEST]) begin
            nxtState.sleepAck = 1'b0;
        end

        // Init acknowledge waits for the internal mode to settle
        if (stateFf.ctl0[can_evt_pkg::C0_INIT_REQUEST] && stateFf.ctl1[can_evt_pkg::C1_MODULE_ENABLE]) begin
            nxtState.initSync = {stateFf.initSync[0], 1'b1};
            nxtState.initAck  = stateFf.initSync[1];
        end else begin
            nxtState.initSync = '0;
            nxtState.initAck  = 1'b0;
        end

        if (!busOffIn) begin
            nxtState.busoffHold = 1'b1;
        end

        nxtState.rdata = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                can_evt_pkg::CTL0_OFS: nxtState.rdata = stateFf.ctl0;
                can_evt_pkg::CTL1_OFS: nxtState.rdata = {stateFf.ctl1[7:2], stateFf.sleepAck, stateFf.initAck};
                can_evt_pkg::RIER_OFS: nxtState.rdata = stateFf.rier;
                can_evt_pkg::TIER_OFS: nxtState.rdata = {5'h00, stateFf.tier};
                can_evt_pkg::TFLG_OFS: nxtState.rdata = {5'h00, stateFf.txEmpty};
                can_evt_pkg::MISC_OFS: nxtState.rdata = {7'h00, stateFf.busoffHold};
                can_evt_pkg::RFLG_OFS: nxtState.rdata = {stateFf.wake, stateFf.statChg, stateFf.rxStateField,
                                                         stateFf.txStateField, stateFf.overrun, stateFf.rxFull};
                default: nxtState.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stateFf <= '{ctl0: can_evt_pkg::CTL0_RST, ctl1: can_evt_pkg::CTL1_RST,
                         rier: can_evt_pkg::RIER_RST, tier: can_evt_pkg::TIER_RST,
                         txEmpty: can_evt_pkg::TXE_RST, busoffHold: 1'b1, rxPipe: 2'h3, default: '0};
        end else begin
            stateFf <= nxtState;
        end
    end

    assign regRdata      = stateFf.rdata;
    assign initMode      = stateFf.initAck;
    assign sleepMode     = stateFf.sleepAck;
    assign busOffRecover = lnk.recoverDone;

    // Enabled flags ORed per group, then gated by the global mask
    assign wakeIrq = globalMask_n && stateFf.wake && stateFf.sleptBeforePd
                     && stateFf.ctl0[can_evt_pkg::C0_WAKE_ENABLE] && stateFf.rier[can_evt_pkg::RF_WUP];
    assign errIrq  = globalMask_n && ((stateFf.statChg && stateFf.rier[can_evt_pkg::RF_CSC])
                     || (stateFf.overrun && stateFf.rier[can_evt_pkg::RF_OVR]));
    assign rxIrq   = globalMask_n && stateFf.rxFull && stateFf.rier[can_evt_pkg::RF_RXF];
    assign txIrq   = globalMask_n && |(stateFf.txEmpty & stateFf.tier);
endmodule // can_irq_wakeup_busoff

// >>> logic/can_evt_pkg.sv
// Package: constants, types and the register map of the CAN event and recovery block.
// Assumes a single 100 MHz clock and the plain strobe register port.
package can_evt_pkg;
    localparam int          AW         = 4;
    localparam int          NUM_TXBUF  = 3;
    localparam logic [3:0]  CTL0_OFS   = 4'h0;
    localparam logic [3:0]  CTL1_OFS   = 4'h1;
    localparam logic [3:0]  RFLG_OFS   = 4'h4;
    localparam logic [3:0]  RIER_OFS   = 4'h5;
    localparam logic [3:0]  TFLG_OFS   = 4'h6;
    localparam logic [3:0]  TIER_OFS   = 4'h7;
    localparam logic [3:0]  MISC_OFS   = 4'h8;
    // control_reg_0 fields
    localparam int          C0_INIT_REQUEST  = 0;
    localparam int          C0_SLEEP_REQUEST   = 1;
    localparam int          C0_WAKE_ENABLE    = 2;
    // control_reg_1 fields
    localparam int          C1_WAKE_FILTER_SELECT    = 2;
    localparam int          C1_BUSOFF_USER_RECOVERY    = 3;
    localparam int          C1_MODULE_ENABLE    = 7;
    // rx_flag_reg fields
    localparam int          RF_RXF     = 0;
    localparam int          RF_OVR     = 1;
    localparam int          RF_TST     = 2;
    localparam int          RF_RST     = 4;
    localparam int          RF_CSC     = 6;
    localparam int          RF_WUP     = 7;
    localparam logic [7:0]  CTL0_RST   = 8'h01;
    localparam logic [7:0]  CTL1_RST   = 8'h00;
    localparam logic [7:0]  RIER_RST   = 8'h00;
    localparam logic [2:0]  TIER_RST   = 3'h0;
    localparam logic [2:0]  TXE_RST    = 3'h7;
    // Bus-off recovery: 128 sequences of 11 recessive bits
    localparam int          BO_SEQS    = 128;
    localparam int          BO_BITS    = 11;
    // Wake filter: activity must hold this long to count
    localparam int          WAKE_FILT_NS = 2000;
    localparam int          CLK_NS       = 10;
    localparam int          WAKE_FILT_CYC = WAKE_FILT_NS / CLK_NS;
    localparam int          INIT_SYNC_CYC = 3;
    typedef enum logic [1:0] {ERR_ACTIVE, ERR_WARN, ERR_PASSIVE, ERR_BUSOFF} errstate_e;
    typedef enum logic [1:0] {M_NORMAL, M_INIT, M_SLEEP} mode_e;
endpackage

// >>> logic/can_evt_if.sv
// Interface: bus-off recovery request and status between the top and the recovery counter.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface can_evt_if;
    logic busOff;
    logic bitTick;
    logic rxRecessive;
    logic userMode;
    logic holdSet;
    logic recoverDone;
    logic seqsDone;
    modport top (output busOff, bitTick, rxRecessive, userMode, holdSet, input recoverDone, seqsDone);
    modport rec (input busOff, bitTick, rxRecessive, userMode, holdSet, output recoverDone, seqsDone);
endinterface

// >>> logic/busoff_recovery.sv
// Bus-off recovery counter: 128 runs of 11 recessive bits, then optional hold release.
// Assumes bitTick is a one-cycle enable per CAN bit and busOff is a level.
`timescale 1ns/1ps
module busoff_recovery #(
    parameter int SEQS = can_evt_pkg::BO_SEQS,
    parameter int BITS = can_evt_pkg::BO_BITS
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    can_evt_if.rec    lnk
);
    typedef struct packed {
        logic [7:0] seqCnt;
        logic [3:0] bitCnt;
        logic       seqsDone;
    } st_s;
    st_s stateFf;
    st_s nxtState;

    always_comb begin
        nxtState = stateFf;
        if (!lnk.busOff) begin
            nxtState = '0;
        end else if (lnk.bitTick && !stateFf.seqsDone) begin
            if (!lnk.rxRecessive) begin
                nxtState.bitCnt = '0;
            end else if (stateFf.bitCnt == 4'(BITS - 1)) begin
                nxtState.bitCnt = '0;
                nxtState.seqCnt = stateFf.seqCnt + 8'h01;
                if (stateFf.seqCnt == 8'(SEQS - 1)) begin
                    nxtState.seqsDone = 1'b1;
                end
            end else begin
                nxtState.bitCnt = stateFf.bitCnt + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign lnk.seqsDone = stateFf.seqsDone;
    // Either order: both must hold in user mode
    assign lnk.recoverDone = stateFf.seqsDone && (!lnk.userMode || !lnk.holdSet);
endmodule // busoff_recovery

// >>> logic/wake_filter.sv
// Wake detector: optional low-pass on the synchronised receive line.
// Assumes rxSync is already synchronised to ref_clk.
`timescale 1ns/1ps
module wake_filter #(
    parameter int FILT_CYC = can_evt_pkg::WAKE_FILT_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic rxSync,
    input  wire logic filterOn,
    input  wire logic armed,
    output logic      wakeHit
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        hit;
    } st_s;
    st_s stateFf;
    st_s nxtState;

    always_comb begin
        nxtState = stateFf;
        nxtState.hit = 1'b0;
        if (!armed || rxSync) begin
            nxtState.cnt = '0;
        end else if (!filterOn) begin
            nxtState.hit = 1'b1;
        end else if (stateFf.cnt == 16'(FILT_CYC - 1)) begin
            nxtState.hit = 1'b1; // Glitches shorter than the window are ignored
        end else begin
            nxtState.cnt = stateFf.cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign wakeHit = stateFf.hit;
endmodule // wake_filter

// >>> tb/can_bus_node.sv
// Partner: the CAN bus as seen at the receive pin, with a free-running bit tick.
// Assumes the bus rests recessive (1) whenever no node drives it.
`timescale 1ns/1ps
module can_bus_node #(
    parameter int TICK_DIV = 2
) (
    input  wire logic ref_clk,
    output logic      rxLine,
    output logic      bitTick
);
    int divCnt;
    initial begin
        rxLine = 1'b1;
        bitTick = 1'b0;
        divCnt = 0;
    end
    // Bit timing never stops, so idle recessive time counts as recessive bits
    always @(posedge ref_clk) begin
        divCnt <= (divCnt + 1) % TICK_DIV;
        bitTick <= (divCnt == 0);
    end
    // Some node drives dominant for n cycles, then the bus falls back recessive
    task automatic dominant(input int n);
        @(posedge ref_clk);
        rxLine <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rxLine <= 1'b1;
    endtask
endmodule // can_bus_node

// >>> tb/can_irq_wakeup_busoff_asserts.sv
// Checker: interrupt, read and bus-off timing seen at the top ports.
// Assumes enables change only by register writes; shadows them to know what may reach an output.
`timescale 1ns/1ps
module can_irq_wakeup_busoff_asserts (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       globalMask_n,
    input wire logic       powerDown,
    input wire logic       bitTick,
    input wire logic [2:0] txScheduled,
    input wire logic       rxToForeground,
    input wire logic       rxFifoOverflow,
    input wire logic       busOffIn,
    input wire logic       busOffRecover,
    input wire logic       sleepMode,
    input wire logic       wakeIrq,
    input wire logic       errIrq,
    input wire logic       rxIrq,
    input wire logic       txIrq
);
    localparam int MIN_TICKS = can_evt_pkg::BO_SEQS * can_evt_pkg::BO_BITS;
    logic [7:0]  rxIeFf;
    logic [2:0]  txIeFf;
    logic [11:0] tickFf;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxIeFf <= 8'h00;
            txIeFf <= 3'h0;
        end else if (regWr && regAddr == can_evt_pkg::RIER_OFS) begin
            rxIeFf <= regWdata;
        end else if (regWr && regAddr == can_evt_pkg::TIER_OFS) begin
            txIeFf <= regWdata[2:0];
        end
    end
    // Lower bound only: the design also needs the runs to be recessive
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tickFf <= 12'h000;
        end else if (!busOffIn) begin
            tickFf <= 12'h000;
        end else if (bitTick && tickFf != 12'hfff) begin
            tickFf <= tickFf + 12'h001;
        end
    end
    a_masked_quiet: assert property (!globalMask_n |-> !(wakeIrq || errIrq || rxIrq || txIrq))
        else $error("interrupt out while globally masked");
    a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property ($past(regRd) && $past(regAddr) > 4'h8 |-> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_tx_empty_irq: assert property (|(~txScheduled & txIeFf) ##1 globalMask_n && $stable(txIeFf) |-> txIrq)
        else $error("idle buffer gave no tx irq");
    a_rx_full_irq: assert property (rxToForeground && !sleepMode ##1 globalMask_n && rxIeFf[0] |-> rxIrq)
        else $error("received message gave no rx irq");
    a_rx_clear: assert property (regWr && regAddr == can_evt_pkg::RFLG_OFS && regWdata[0] && !rxToForeground |=> !rxIrq)
        else $error("rx irq survived its clear");
    a_overrun_irq: assert property (rxFifoOverflow ##1 globalMask_n && rxIeFf[1] |-> errIrq)
        else $error("overrun gave no error irq");
    a_recover_late: assert property (busOffRecover && busOffIn |-> tickFf >= MIN_TICKS)
        else $error("bus-off recovery too early");
    a_wake_cause: assert property ($rose(wakeIrq) && $stable(globalMask_n) && !$past(regWr)
        |-> $past(sleepMode) || $past(sleepMode, 2) || $past(powerDown))
        else $error("wake irq outside low power");
    c_wake: cover property ($rose(wakeIrq));
    c_recover: cover property ($rose(busOffRecover));
    c_rx: cover property (rxToForeground ##1 rxIrq);
endmodule // can_irq_wakeup_busoff_asserts
bind can_irq_wakeup_busoff can_irq_wakeup_busoff_asserts chk (.ref_clk, .rst, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .globalMask_n, .powerDown, .bitTick, .txScheduled, .rxToForeground, .rxFifoOverflow,
    .busOffIn, .busOffRecover, .sleepMode, .wakeIrq, .errIrq, .rxIrq, .txIrq);

// >>> tb/can_irq_wakeup_busoff_test.sv
// Testbench: registers, frame events and a bus model around the CAN event block.
// Assumes default filter and bus-off counts; the bus model ticks every second clock.
`timescale 1ns/1ps
module can_irq_wakeup_busoff_test;
    localparam logic [3:0] C0 = can_evt_pkg::CTL0_OFS, C1 = can_evt_pkg::CTL1_OFS, MS = can_evt_pkg::MISC_OFS;
    localparam logic [3:0] RF = can_evt_pkg::RFLG_OFS, RE = can_evt_pkg::RIER_OFS;
    localparam logic [3:0] TF = can_evt_pkg::TFLG_OFS, TE = can_evt_pkg::TIER_OFS;
    localparam int         W_INIT = 0, W_SLEEP = 1, W_REC = 2;
    logic       ref_clk, rst, regWr, regRd, globalMask_n, powerDown, busIdle, rxToForeground;
    logic       rxFifoOverflow, busOffIn, busOffRecover, initMode, sleepMode, rxLine, bitTick;
    logic       wakeIrq, errIrq, rxIrq, txIrq, m;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, rdVal;
    logic [2:0] txScheduled, s;
    logic [1:0] txErrState, rxErrState;
    int         errors, n_checks, i;
    can_bus_node node (.ref_clk, .rxLine, .bitTick);
    can_irq_wakeup_busoff dut (.ref_clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .bus_rx_pin(rxLine), .globalMask_n, .powerDown, .bitTick, .busIdle, .txScheduled, .rxToForeground,
        .rxFifoOverflow, .txErrState, .rxErrState, .busOffIn, .busOffRecover, .initMode, .sleepMode,
        .wakeIrq, .errIrq, .rxIrq, .txIrq);
    function automatic logic [7:0] stateFlags(input logic [1:0] tx, input logic [1:0] rx);
        return {2'b01, rx, tx, 2'b00};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Also ends a message pulse raised beside the write, for set-versus-clear races
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        {regWr, rxToForeground} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 rdVal = regRdata;
        check(rdVal, exp, what);
        @(posedge ref_clk);
    endtask
    task automatic evt(input logic ovr);
        if (ovr) rxFifoOverflow <= 1'b1;
        else rxToForeground <= 1'b1;
        @(posedge ref_clk);
        {rxFifoOverflow, rxToForeground} <= 2'b00;
        @(posedge ref_clk);
    endtask
    function automatic logic pick(input int which);
        return (which == W_INIT) ? initMode : (which == W_SLEEP) ? sleepMode : busOffRecover;
    endfunction
    task automatic waitOn(input int which, input logic lvl, input int lim);
        int k;
        k = 0;
        while (pick(which) !== lvl) begin
            @(posedge ref_clk);
            k++;
            if (k > lim) begin
                check(8'(pick(which)), 8'(lvl), "wait");
                report_and_stop();
            end
        end
    endtask
    task automatic startUp(input logic [7:0] c1);
        wr(C1, c1);
        waitOn(W_INIT, 1'b1, 20);
        wr(C0, 8'h00);
        waitOn(W_INIT, 1'b0, 20);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        {regWr, regRd, powerDown, rxToForeground, rxFifoOverflow, busOffIn} = '0;
        {regAddr, regWdata, txScheduled, txErrState, rxErrState} = '0;
        globalMask_n = 1'b1;
        busIdle = 1'b1;
        void'($urandom(32'h9f1e0b71));
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(C0, can_evt_pkg::CTL0_RST, "ctl0 reset");
        rd(TF, {5'h00, can_evt_pkg::TXE_RST}, "txFlag reset");
        wr(4'ha, 8'hff);
        rd(4'ha, 8'h00, "unmapped");
        check(8'(initMode), 8'h00, "init ack before enable");
        startUp(8'h84);
        wr(TE, 8'h07);
        for (i = 0; i < 8; i++) begin
            s = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
            txScheduled <= s;
            wr(TF, 8'h07);
            rd(TF, {5'h00, ~s}, "txFlag");
            check(8'(txIrq), 8'(|(~s)), "txIrq");
        end
        txScheduled <= 3'h0;
        @(posedge ref_clk);
        txScheduled <= 3'h7;
        wr(TF, 8'h00);
        rd(TF, 8'h07, "txFlag w0");
        wr(TF, 8'h02);
        rd(TF, 8'h05, "txFlag w1");
        globalMask_n <= 1'b0;
        @(posedge ref_clk);
        check(8'(txIrq), 8'h00, "txIrq masked");
        globalMask_n <= 1'b1;
        wr(TF, 8'h05);
        check(8'(txIrq), 8'h00, "txIrq cleared");
        wr(RE, 8'h03);
        for (i = 0; i < 10; i++) begin
            m = 1'($urandom);
            globalMask_n <= m;
            evt(1'b0);
            check(8'(rxIrq), 8'(m), "rxIrq");
            wr(RF, 8'h01);
            check(8'(rxIrq), 8'h00, "rxIrq clear");
        end
        globalMask_n <= 1'b1;
        rxToForeground <= 1'b1;
        wr(RF, 8'h01);
        check(8'(rxIrq), 8'h01, "set beats clear");
        evt(1'b1);
        wr(RF, 8'h01);
        check(8'(errIrq), 8'h01, "errIrq kept");
        wr(RF, 8'h02);
        check(8'(errIrq), 8'h00, "errIrq clear");
        wr(RE, 8'h40);
        for (i = 1; i < 4; i++) begin
            txErrState <= 2'(i);
            rxErrState <= 2'(3 - i);
            repeat (2) @(posedge ref_clk);
            rd(RF, stateFlags(2'(i), 2'(3 - i)), "state flags");
            check(8'(errIrq), 8'h01, "errIrq status");
            wr(RF, 8'h40);
        end
        {txErrState, rxErrState} <= 4'h0;
        repeat (2) @(posedge ref_clk);
        wr(RF, 8'h40);
        wr(RE, 8'h80);
        txScheduled <= 3'h1;
        busIdle <= 1'b0;
        wr(TF, 8'h07);
        wr(C0, 8'h06);
        repeat (20) @(posedge ref_clk);
        check(8'(sleepMode), 8'h00, "sleep while sending");
        txScheduled <= 3'h0;
        repeat (10) @(posedge ref_clk);
        check(8'(sleepMode), 8'h00, "sleep while bus busy");
        busIdle <= 1'b1;
        waitOn(W_SLEEP, 1'b1, 50);
        rd(C1, 8'h86, "ctl1 asleep");
        node.dominant(20);
        repeat (250) @(posedge ref_clk);
        check(8'(sleepMode), 8'h01, "glitch ignored");
        node.dominant(300);
        check(8'(wakeIrq), 8'h01, "wakeIrq");
        check(8'(sleepMode), 8'h00, "woken");
        wr(RF, 8'h80);
        check(8'(wakeIrq), 8'h00, "wake clear");
        wr(C0, 8'h02);
        waitOn(W_SLEEP, 1'b1, 50);
        node.dominant(300);
        check(8'(sleepMode), 8'h01, "no wake unarmed");
        check(8'(wakeIrq), 8'h00, "no wake irq");
        wr(C0, 8'h03);
        waitOn(W_INIT, 1'b1, 20);
        wr(C1, 8'h84);
        wr(C0, 8'h00);
        waitOn(W_SLEEP, 1'b0, 50);
        wr(C0, 8'h04);
        powerDown <= 1'b1;
        node.dominant(300);
        check(8'(wakeIrq), 8'h00, "power-down unslept");
        powerDown <= 1'b0;
        wr(RF, 8'h80);
        busOffIn <= 1'b1;
        repeat (1300) @(posedge ref_clk);
        check(8'(busOffRecover), 8'h00, "recover early");
        waitOn(W_REC, 1'b1, 3000);
        busOffIn <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        startUp(8'h88);
        rd(MS, 8'h01, "hold set");
        busOffIn <= 1'b1;
        repeat (3200) @(posedge ref_clk);
        check(8'(busOffRecover), 8'h00, "held");
        wr(MS, 8'h01);
        check(8'(busOffRecover), 8'h01, "released");
        busOffIn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        busOffIn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        wr(MS, 8'h01);
        repeat (200) @(posedge ref_clk);
        check(8'(busOffRecover), 8'h00, "hold first");
        waitOn(W_REC, 1'b1, 3200);
        report_and_stop();
    end
endmodule // can_irq_wakeup_busoff_test
